// *** drive_select_pkg.sv ***
package drive_select_pkg;

  // register byte addresses (index times four)
  localparam logic [3:0] tape_assign_idx   = 4'h3;
  localparam logic [3:0] dig_out_idx       = 4'h2;
  localparam logic [3:0] cfg_five_idx      = 4'h5;
  localparam logic [3:0] tape_active_idx   = 4'h6;
  localparam logic [5:0] tape_assign_addr  = {tape_assign_idx, 2'b00};
  localparam logic [5:0] dig_out_addr      = {dig_out_idx, 2'b00};
  localparam logic [5:0] cfg_five_addr     = {cfg_five_idx, 2'b00};
  localparam logic [5:0] tape_active_addr  = {tape_active_idx, 2'b00};

  // digital output register fields
  localparam int unsigned dor_sel_lsb      = 0;
  localparam int unsigned dor_rst_bit      = 2;
  localparam int unsigned dor_dma_bit      = 3;
  localparam int unsigned dor_mot_lsb      = 4;

  // configuration register five fields
  localparam int unsigned cfg_swap_bit     = 0;
  localparam int unsigned cfg_ext_bit      = 1;
  localparam int unsigned cfg_enh_bit      = 2;

  localparam logic [7:0] dor_reset_val     = 8'h00;
  localparam logic [7:0] cfg_reset_val     = 8'h00;
  localparam logic [1:0] tape_reset_val    = 2'h0;
  localparam logic [1:0] tape_none_code    = 2'h0;

  typedef struct packed {
    logic       sel1_n;
    logic       sel0_n;
    logic       mot1_n;
    logic       mot0_n;
  } drive_pins_s;

  localparam drive_pins_s pins_idle        = '{sel1_n: 1'b1, sel0_n: 1'b1,
                                               mot1_n: 1'b1, mot0_n: 1'b1};

endpackage

// *** drive_select_decode_tape_reg.sv ***
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps

module drive_select_decode_tape_reg (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [5:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic      [7:0]                wb_dat_oe_n_o,
  output logic                           wb_ack_o,
  output logic                           wb_err_o,
  output logic                           drv_select_out0_n_o,
  output logic                           drv_select_out1_n_o,
  output logic                           motor_on_out0_n_o,
  output logic                           motor_on_out1_n_o,
  output logic                           soft_reset_o,
  output logic                           dma_enable_o,
  output logic                           tape_active_o
);
  import drive_select_pkg::*;

  logic [7:0]  digital_output_ctl_q;
  logic [7:0]  config_register_five_q;
  logic [1:0]  tape_select_q;
  drive_pins_s pins_q;
  logic        soft_reset_q;
  logic        dma_q;
  logic        tape_active_q;
  logic [31:0] dat_q;
  logic [7:0]  oe_n_q;
  logic        ack_q;
  logic        err_q;

  // bus decode
  wire         req       = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  wire         hit_tape  = (wb_adr_i == tape_assign_addr);
  wire         hit_dor   = (wb_adr_i == dig_out_addr);
  wire         hit_cfg   = (wb_adr_i == cfg_five_addr);
  wire         hit_act   = (wb_adr_i == tape_active_addr);
  wire         hit_any   = hit_tape | hit_dor | hit_cfg | hit_act;
  wire         wr_lane0  = req & wb_we_i & wb_sel_i[0];
  wire         wr_tape   = wr_lane0 & hit_tape;
  wire         wr_dor    = wr_lane0 & hit_dor;
  wire         wr_cfg    = wr_lane0 & hit_cfg;

  wire [7:0]   dor_d     = wr_dor ? wb_dat_i[7:0] : digital_output_ctl_q;
  wire [7:0]   cfg_d     = wr_cfg ? wb_dat_i[7:0] : config_register_five_q;
  wire [1:0]   tape_d    = wr_tape ? wb_dat_i[1:0] : tape_select_q;

  wire         swap      = cfg_d[cfg_swap_bit];
  wire         ext_mode  = cfg_d[cfg_ext_bit];
  wire         enh_mode  = config_register_five_q[cfg_enh_bit];
  wire [1:0]   select_drive_zero = dor_d[dor_sel_lsb +: 2];
  wire [3:0]   motor_drive_zero  = dor_d[dor_mot_lsb +: 4];

  // swaps drive numbers 0 and 1, leaves 2 and 3
  function automatic logic [1:0] swap01(input logic [1:0] code, input logic en);
    swap01 = (en && code[1] == 1'b0) ? {1'b0, ~code[0]} : code;
  endfunction

  wire [1:0]   phys_code = swap01(select_drive_zero, swap);
  wire         mot_sel   = motor_drive_zero[select_drive_zero];
  wire         int_sel0  = (phys_code == 2'h0) & mot_sel;
  wire         int_sel1  = (phys_code == 2'h1) & mot_sel;
  wire [1:0]   int_mot   = swap ? {motor_drive_zero[0], motor_drive_zero[1]}
                                : {motor_drive_zero[1], motor_drive_zero[0]};

  drive_pins_s pins_int;
  drive_pins_s pins_ext;
  drive_pins_s pins_d;
  // an all-zero motor field gives mot_sel zero, so no select drops
  assign pins_int = '{sel1_n: ~int_sel1, sel0_n: ~int_sel0,
                      mot1_n: ~int_mot[1], mot0_n: ~int_mot[0]};
  // one shared motor line; the outboard decoder routes it by the code
  assign pins_ext = '{sel1_n: phys_code[1], sel0_n: phys_code[0],
                      mot1_n: 1'b1, mot0_n: ~mot_sel};
  assign pins_d   = ext_mode ? pins_ext : pins_int;

  // tape drive is the one named by the code; zero code means none
  wire         tape_hit  = (tape_select_q != tape_none_code) &&
                           (select_drive_zero == tape_select_q);

  wire [7:0]   tape_rd   = {6'h00, tape_select_q};
  wire [7:0]   rd_byte   = hit_tape ? tape_rd :
                           hit_dor  ? digital_output_ctl_q :
                           hit_cfg  ? config_register_five_q :
                           {7'h00, tape_active_q};
  // normal mode floats the upper tape bits; enhanced fields are not built, read zero
  wire [7:0]   oe_n_d    = (req & ~wb_we_i & hit_tape & ~enh_mode) ? 8'hfc :
                           (req & ~wb_we_i & hit_any) ? 8'h00 : 8'hff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      digital_output_ctl_q   <= dor_reset_val;
      config_register_five_q <= cfg_reset_val;
      tape_select_q          <= tape_reset_val;
      pins_q                 <= pins_idle;
      soft_reset_q           <= 1'b1;
      dma_q                  <= 1'b0;
      tape_active_q          <= 1'b0;
      dat_q                  <= 32'h0000_0000;
      oe_n_q                 <= 8'hff;
      ack_q                  <= 1'b0;
      err_q                  <= 1'b0;
    end else begin
      digital_output_ctl_q   <= dor_d;
      config_register_five_q <= cfg_d;
      tape_select_q          <= tape_d;
      pins_q                 <= pins_d;
      soft_reset_q           <= ~dor_d[dor_rst_bit];
      dma_q                  <= dor_d[dor_dma_bit];
      tape_active_q          <= tape_hit;
      dat_q                  <= (req & ~wb_we_i & hit_any) ? {24'h00_0000, rd_byte} : 32'h0;
      oe_n_q                 <= oe_n_d;
      ack_q                  <= req & hit_any;
      err_q                  <= req & ~hit_any;
    end
  end

  assign wb_dat_o            = dat_q;
  assign wb_dat_oe_n_o       = oe_n_q;
  assign wb_ack_o            = ack_q;
  assign wb_err_o            = err_q;
  assign drv_select_out0_n_o = pins_q.sel0_n;
  assign drv_select_out1_n_o = pins_q.sel1_n;
  assign motor_on_out0_n_o   = pins_q.mot0_n;
  assign motor_on_out1_n_o   = pins_q.mot1_n;
  assign soft_reset_o        = soft_reset_q;
  assign dma_enable_o        = dma_q;
  assign tape_active_o       = tape_active_q;

  // checks
  a_int_idle_selects: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ext_mode && motor_drive_zero == 4'h0) |=> (drv_select_out0_n_o && drv_select_out1_n_o))
    else $error("select low with all motors off");

  a_int_plain_sel0: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ext_mode && !swap && select_drive_zero == 2'h0 && motor_drive_zero[0])
      |=> (!drv_select_out0_n_o && drv_select_out1_n_o))
    else $error("internal plain drive 0 select wrong");

  a_int_swap_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ext_mode && swap && select_drive_zero == 2'h0 && motor_drive_zero[0])
      |=> (drv_select_out0_n_o && !drv_select_out1_n_o))
    else $error("internal swapped drive 0 select wrong");

  a_int_swap_motors: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ext_mode && swap) |=> (motor_on_out1_n_o == !$past(motor_drive_zero[0])
                             && motor_on_out0_n_o == !$past(motor_drive_zero[1])))
    else $error("swapped motor outputs wrong");

  a_ext_plain_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_mode && !swap) |=> ({drv_select_out1_n_o, drv_select_out0_n_o}
                              == $past(select_drive_zero) && motor_on_out1_n_o))
    else $error("external code not passed");

  a_ext_swap_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_mode && swap && select_drive_zero == 2'h1)
      |=> ({drv_select_out1_n_o, drv_select_out0_n_o} == 2'h0))
    else $error("external swap code wrong");

  a_tape_never_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    tape_active_o |-> ($past(tape_select_q) != 2'h0 && $past(select_drive_zero) != 2'h0))
    else $error("tape flagged for drive 0");

  a_tape_write_read: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_tape |=> (tape_select_q == $past(wb_dat_i[1:0])))
    else $error("tape select not stored");

  a_tape_float_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_tape && !enh_mode) |=> (wb_ack_o && wb_dat_oe_n_o == 8'hfc))
    else $error("tape upper bits driven");

  a_soft_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (soft_reset_o && !wr_dor) |=> soft_reset_o)
    else $error("soft reset released without write");

  a_int_plain_sel1: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ext_mode && !swap && select_drive_zero == 2'h1 && motor_drive_zero[1])
      |=> (drv_select_out0_n_o && !drv_select_out1_n_o))
    else $error("internal plain drive 1 select wrong");

  a_int_swap_sel1: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ext_mode && swap && select_drive_zero == 2'h1 && motor_drive_zero[1])
      |=> (!drv_select_out0_n_o && drv_select_out1_n_o))
    else $error("internal swapped drive 1 select wrong");

  // internal scheme has no pins for drives 2 and 3
  a_int_high_codes: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ext_mode && select_drive_zero[1])
      |=> (drv_select_out0_n_o && drv_select_out1_n_o))
    else $error("internal select low for drive 2 or 3");

  a_int_plain_motors: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ext_mode && !swap) |=> (motor_on_out1_n_o == !$past(motor_drive_zero[1])
                              && motor_on_out0_n_o == !$past(motor_drive_zero[0])))
    else $error("plain motor outputs wrong");

  a_ext_swap_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_mode && swap && select_drive_zero[1])
      |=> ({drv_select_out1_n_o, drv_select_out0_n_o} == $past(select_drive_zero)))
    else $error("external swap changed codes 2 or 3");

  a_ext_swap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ext_mode && swap && select_drive_zero == 2'h0)
      |=> ({drv_select_out1_n_o, drv_select_out0_n_o} == 2'h1 && motor_on_out1_n_o))
    else $error("external swap code zero wrong");

  a_ext_motor_line: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_mode |=> (motor_on_out0_n_o == !$past(motor_drive_zero[select_drive_zero])))
    else $error("external motor line wrong");

  a_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  a_bus_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !hit_any) |=> (wb_err_o && !wb_ack_o))
    else $error("unmapped access not refused");

  a_soft_reset_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_dor && wb_dat_i[dor_rst_bit]) |=> !soft_reset_o)
    else $error("soft reset not released by write");

  a_tape_code_match: assert property (@(posedge clk_i) disable iff (rst_i)
    (tape_select_q != 2'h0 && select_drive_zero == tape_select_q) |=> tape_active_o)
    else $error("tape drive not flagged");

  // soft reset must not disturb the tape assignment
  a_tape_soft_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (soft_reset_o && !wr_tape) |=> $stable(tape_select_q))
    else $error("tape select lost in soft reset");

endmodule

// *** drive_pair_model.sv ***
`timescale 1ns/1ps
module drive_pair_model (
  input  wire logic       sel0_n_i,
  input  wire logic       sel1_n_i,
  input  wire logic       mot0_n_i,
  input  wire logic       mot1_n_i,
  output logic      [1:0] spin_o
);
  // a drive answers only while both its select and its motor are low
  assign spin_o = {~sel1_n_i & ~mot1_n_i, ~sel0_n_i & ~mot0_n_i};
endmodule

// *** drive_select_decode_tape_reg_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error at %0t got %h expected %h", $time, (a), (e)); end end
module drive_select_decode_tape_reg_tb_top;
  import drive_select_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, err, s0, s1, m0, m1, srst, dma, tact, rerr;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, dat_o, rd;
  logic [7:0]  oe_n, roe;
  logic [1:0]  spin;
  int          error_cnt = 0, checks_done = 0, cycles = 0;
  drive_select_decode_tape_reg uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_dat_oe_n_o(oe_n), .wb_ack_o(ack), .wb_err_o(err),
    .drv_select_out0_n_o(s0), .drv_select_out1_n_o(s1), .motor_on_out0_n_o(m0),
    .motor_on_out1_n_o(m1), .soft_reset_o(srst), .dma_enable_o(dma), .tape_active_o(tact));
  drive_pair_model drives (.sel0_n_i(s0), .sel1_n_i(s1), .mot0_n_i(m0), .mot1_n_i(m1),
    .spin_o(spin));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h0, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    if (n == 20) `CHK(n, 0)
    rd = dat_o; roe = oe_n; rerr = err;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // pins take the new value on the write edge itself; settle waits one edge more
  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask
  function automatic logic [3:0] exp_pins(logic [7:0] d, logic [1:0] c);
    logic [1:0] s;
    logic [3:0] m;
    s = d[1:0];
    m = d[7:4];
    if (c[1]) return {((c[0] && !s[1]) ? {1'b0, ~s[0]} : s), 1'b1, ~m[s]};
    if (c[0]) return {!(s == 0 && m[0]), !(s == 1 && m[1]), ~m[0], ~m[1]};
    return {!(s == 1 && m[1]), !(s == 0 && m[0]), ~m[1], ~m[0]};
  endfunction
  task automatic t_reset;
    #1;
    `CHK({s1, s0, m1, m0}, 4'hf)
    `CHK(srst, 1'b1)
    `CHK(dma, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_decode;
    logic [7:0] dv;
    logic [3:0] mp[4];
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, cfg_five_addr, 8'(c));
      for (int s = 0; s < 4; s++) begin
        mp = '{4'h0, 4'hf, 4'h1 << s, ~(4'h1 << s)};
        for (int k = 0; k < 4; k++) begin
          dv = {mp[k], 2'b01, 2'(s)};
          bus(1'b1, dig_out_addr, dv);
          settle();
          if (c == 0) `CHK({s1, s0, m1, m0}, exp_pins(dv, 2'(c)))
          if (c == 1) `CHK({s1, s0, m1, m0}, exp_pins(dv, 2'(c)))
          if (c == 2) `CHK({s1, s0, m1, m0}, exp_pins(dv, 2'(c)))
          if (c == 3) `CHK({s1, s0, m1, m0}, exp_pins(dv, 2'(c)))
          if (c < 2) `CHK(spin != 2'b11, 1'b1)
          bus(1'b0, dig_out_addr, 8'h00);
          `CHK(rd, {24'h0, dv})
        end
      end
    end
    $display("test decode done");
  endtask
  task automatic t_tape;
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, tape_assign_addr, {6'h3f, 2'(t)});
      bus(1'b0, tape_assign_addr, 8'h00);
      `CHK(rd[1:0], 2'(t))
      `CHK(roe, 8'hfc)
      for (int dr = 0; dr < 4; dr++) begin
        bus(1'b1, dig_out_addr, {6'h01, 2'(dr)});
        settle();
        `CHK(tact, (t != 0 && dr == t))
        if (dr == 0) `CHK(tact, 1'b0)
      end
    end
    bus(1'b1, dig_out_addr, 8'h00);
    settle();
    `CHK(srst, 1'b1)
    `CHK(dma, 1'b0)
    bus(1'b1, dig_out_addr, 8'h0c);
    settle();
    `CHK(srst, 1'b0)
    `CHK(dma, 1'b1)
    bus(1'b0, tape_assign_addr, 8'h00);
    `CHK(rd[1:0], 2'h3)
    bus(1'b1, cfg_five_addr, 8'h04);
    bus(1'b0, tape_assign_addr, 8'h00);
    `CHK(roe, 8'h00)
    `CHK(rd, 32'h0000_0003)
    bus(1'b1, cfg_five_addr, 8'h00);
    bus(1'b0, 6'h3c, 8'h00);
    `CHK(rerr, 1'b1)
    $display("test tape done");
  endtask
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; wdat = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_decode();
    t_tape();
    stop_test();
  end
endmodule
